//--- src/clt_core.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Calibration injects a tone on every receive path, measures it looped back.
// R2 - Each channel gain is trimmed to match reference channel four.
// R3 - A channel outside 0.2 dB of the reference gets its fail flag.
// R4 - A failed channel keeps 0 dB trim and stays usable.
// R5 - Fail masks live at word 0x07f4 for transmit, 0x07f5 for receive.
// R6 - Trims are kept and folded in whenever an absolute gain is written.
// R7 - Host runs calibration after every hardware reset before normal use.
// R8 - Firmware loads into engine RAM over four test pins and can replace ROM.
// R9 - Per-slot transmit and receive routine addresses pick what each channel runs.
// R10 - Loopback routine copies PCM receive data unchanged to PCM transmit.
// R11 - Tone generation plays a table sine of up to 1024 points, filter bypassed.
// R12 - Tone detection measures one frequency by DFT without transmit bandpass.
// R13 - Host picks detection frame count, a power of two.
// R14 - dc generation drives the user dc value on the receive path.
// R15 - dc measurement gives an average and the difference of two averages.
// R16 - Variance of filtered transmit noise about its mean.
// R17 - Peak detection keeps the largest and smallest transmit samples.
// R18 - One peak variant scales by transmit gain, the other does not.
// R19 - Host writes 0x0700, then 0x0720, to word 0x0002 to start calibration.
// R20 - Host waits 70 ms after each calibration phase start.
// R21 - Fail mask bit n belongs to channel n, sixteen channels.
module clt_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // Microprocessor word port
    input wire clt_pkg::clt_host_t host,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    // Channel sample stream
    input wire clt_pkg::clt_samp_t samp,
    output clt_pkg::clt_out_t chan_out,
    output logic cal_busy,
    // Test access pins
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    output logic tdo,
    // Code fetch
    input wire logic [9:0] fetch_addr,
    input wire logic [15:0] rom_data,
    output logic [15:0] fetch_data,
    output logic exec_from_ram
);
    typedef struct packed {
        logic [15:0][15:0] txrt, rxrt, txabs, rxabs, txg, rxg, txtrim, rxtrim;
        logic [15:0] txmask, rxmask, step, dcval, phase;
        logic [3:0] mch, mlog;
        logic mbusy, mdone, mfin;
        logic [15:0] mcnt;
        logic signed [47:0] sum, fsum, re, im;
        logic [47:0] sq;
        logic signed [15:0] dcest, avg, pavg, dif, vmax, vmin, vres, dft;
        clt_pkg::clt_cal_t cst;
        logic cph, crun;
        logic [7:0] cfrm;
        logic [3:0] cch;
        logic [15:0][23:0] cacc;
        clt_pkg::clt_out_t o;
        logic [15:0] rdata;
        logic rvalid, tckp, jexec;
        logic [31:0] jsr;
    } clt_st_t;
    clt_st_t q;
    clt_st_t d;

    logic [2:0] pins_s;
    logic [15:0] sin_rd, cos_rd, fw_rd, fw_wd;
    logic [9:0] fw_wa;
    logic fw_we, sine_we;

    function automatic logic in_blk(input logic [15:0] a, input logic [15:0] b);
        return a[15:4] == b[15:4];
    endfunction

    function automatic logic signed [15:0] smul(input logic signed [15:0] x,
                                                input logic [15:0] g);
        logic signed [32:0] p;
        p = x * $signed({1'b0, g});
        return p[29:14];
    endfunction

    function automatic logic [15:0] gmul(input logic [15:0] g, input logic [15:0] t);
        logic [31:0] p;
        p = g * t;
        return p[29:14];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    clt_sync #(.W(3)) u_sync (
        .clk(core_clk),
        .srst(srst),
        .ce(ce),
        .din({tck_pin, tms_pin, tdi_pin}),
        .dout(pins_s)
    );

    assign sine_we = host.wr && (host.addr[15:10] == clt_pkg::A_SINE[15:10]);

    clt_ram #(.AW(10), .DW(16)) u_sine (
        .clk(core_clk),
        .ce(ce),
        .we(sine_we),
        .waddr(host.addr[9:0]),
        .wdata(host.wdata),
        .raddr_a(q.phase[15:6]),
        .raddr_b(q.phase[15:6] + 10'h100),
        .rdata_a(sin_rd),
        .rdata_b(cos_rd)
    );

    clt_ram #(.AW(10), .DW(16)) u_fw (
        .clk(core_clk),
        .ce(ce),
        .we(fw_we),
        .waddr(fw_wa),
        .wdata(fw_wd),
        .raddr_a(fetch_addr),
        .raddr_b(10'h000),
        .rdata_a(fw_rd),
        .rdata_b()
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [3:0] k;
        logic signed [15:0] x, hp, pk, fm, rn, inn;
        logic signed [31:0] p1, p2;
        logic [32:0] e33;
        logic signed [47:0] t48;
        logic [47:0] u48;
        logic [23:0] ra, av, df;
        logic [39:0] lhs, rhs;
        logic [37:0] quo;
        logic [15:0] ax, trim;
        logic fail;
        k = 4'h0; x = '0; hp = '0; pk = '0; fm = '0; rn = '0; inn = '0;
        p1 = '0; p2 = '0; e33 = '0; t48 = '0; u48 = '0; ra = '0; av = '0;
        df = '0; lhs = '0; rhs = '0; quo = '0; ax = '0; trim = '0; fail = 1'b0;
        fw_we = 1'b0; fw_wa = q.jsr[25:16]; fw_wd = q.jsr[15:0];
        d = q;
        d.rvalid = 1'b0;
        d.o.vld = 1'b0;

        // Host writes
        k = host.addr[3:0];
        if (host.wr) begin
            // R19 calibration start
            if (host.addr == clt_pkg::A_CMD && q.cst == clt_pkg::CAL_IDLE &&
                (host.wdata == clt_pkg::CMD_CAL1 || host.wdata == clt_pkg::CMD_CAL2)) begin
                d.cst = clt_pkg::CAL_ACC;
                d.cph = (host.wdata == clt_pkg::CMD_CAL2);
                d.crun = 1'b0;
                d.cfrm = 8'h00;
                d.cacc = '0;
            end
            // R9 routine table
            if (in_blk(host.addr, clt_pkg::A_TXRT)) d.txrt[k] = host.wdata;
            if (in_blk(host.addr, clt_pkg::A_RXRT)) d.rxrt[k] = host.wdata;
            // R6 trim folded in
            if (in_blk(host.addr, clt_pkg::A_TXG)) begin
                d.txabs[k] = host.wdata;
                d.txg[k] = gmul(host.wdata, q.txtrim[k]);
            end
            if (in_blk(host.addr, clt_pkg::A_RXG)) begin
                d.rxabs[k] = host.wdata;
                d.rxg[k] = gmul(host.wdata, q.rxtrim[k]);
            end
            case (host.addr)
                clt_pkg::A_STEP: d.step = host.wdata;
                clt_pkg::A_DCVAL: d.dcval = host.wdata;
                clt_pkg::A_MCH: d.mch = host.wdata[3:0];
                clt_pkg::A_MLOG: d.mlog = host.wdata[3:0];
                clt_pkg::A_MGO: begin
                    d.mbusy = 1'b1; d.mdone = 1'b0; d.mcnt = 16'h0000;
                    d.sum = '0; d.fsum = '0; d.re = '0; d.im = '0; d.sq = '0;
                    d.vmax = 16'sh8000; d.vmin = 16'sh7fff;
                end
                default: ;
            endcase
        end

        // Host reads
        if (host.rd) begin
            d.rvalid = 1'b1;
            d.rdata = 16'h0000;
            if (in_blk(host.addr, clt_pkg::A_TXRT)) d.rdata = q.txrt[k];
            if (in_blk(host.addr, clt_pkg::A_RXRT)) d.rdata = q.rxrt[k];
            if (in_blk(host.addr, clt_pkg::A_TXG)) d.rdata = q.txabs[k];
            if (in_blk(host.addr, clt_pkg::A_RXG)) d.rdata = q.rxabs[k];
            if (in_blk(host.addr, clt_pkg::A_TXTRIM)) d.rdata = q.txtrim[k];
            if (in_blk(host.addr, clt_pkg::A_RXTRIM)) d.rdata = q.rxtrim[k];
            case (host.addr)
                clt_pkg::A_TXMASK: d.rdata = q.txmask;
                clt_pkg::A_RXMASK: d.rdata = q.rxmask;
                clt_pkg::A_STEP: d.rdata = q.step;
                clt_pkg::A_DCVAL: d.rdata = q.dcval;
                clt_pkg::A_MCH: d.rdata = {12'h000, q.mch};
                clt_pkg::A_MLOG: d.rdata = {12'h000, q.mlog};
                clt_pkg::A_MSTAT: d.rdata = {13'h0000, cal_busy, q.mdone, q.mbusy};
                clt_pkg::A_RDFT: d.rdata = q.dft;
                clt_pkg::A_RAVG: d.rdata = q.avg;
                clt_pkg::A_RDIF: d.rdata = q.dif;
                clt_pkg::A_RVAR: d.rdata = q.vres;
                clt_pkg::A_RMAX: d.rdata = q.vmax;
                clt_pkg::A_RMIN: d.rdata = q.vmin;
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        if (samp.vld) begin
            k = samp.ch;
            x = samp.tx;
            d.o.vld = 1'b1;
            d.o.ch = k;
            d.o.rx_byp = 1'b0;
            // R9 receive routine
            case (q.rxrt[k])
                clt_pkg::RT_ACTIVE: d.o.rx = smul(samp.pcm, q.rxg[k]);
                // R11 table sine, filter bypassed
                clt_pkg::RT_TONE: begin
                    d.o.rx = sin_rd;
                    d.o.rx_byp = 1'b1;
                end
                // R14 constant dc
                clt_pkg::RT_DCGEN: d.o.rx = q.dcval;
                default: d.o.rx = 16'h0000;
            endcase
            // R9 transmit routine
            case (q.txrt[k])
                clt_pkg::RT_ACTIVE: d.o.pcm = smul(x, q.txg[k]);
                // R10 untouched copy
                clt_pkg::RT_LOOP: d.o.pcm = samp.pcm;
                default: d.o.pcm = 16'h0000;
            endcase
            // R12 no bandpass for detection
            d.o.tx_bpf = (q.txrt[k] == clt_pkg::RT_ACTIVE) || (q.txrt[k] == clt_pkg::RT_VAR);
            if (k == 4'hf) d.phase = q.phase + q.step;

            // R1 inject a fs/2 sine and sum looped-back amplitude
            if (q.cst == clt_pkg::CAL_ACC) begin
                d.o.rx = q.cfrm[0] ? (16'h0000 - clt_pkg::CAL_AMP) : clt_pkg::CAL_AMP;
                ax = x[15] ? (16'h0000 - x) : x;
                if (q.crun) d.cacc[k] = q.cacc[k] + {8'h00, ax};
                if (k == 4'hf) begin
                    d.crun = 1'b1;
                    if (q.crun) d.cfrm = q.cfrm + 8'h01;
                    if (q.crun && q.cfrm == clt_pkg::CAL_FRAMES - 8'h01) begin
                        d.cst = clt_pkg::CAL_EVAL;
                        d.cch = 4'h0;
                    end
                end
            end

            if (q.mbusy && k == q.mch) begin
                // R16 high-pass ahead of variance
                hp = x - q.dcest;
                d.dcest = q.dcest + (hp >>> clt_pkg::HPF_SH);
                d.sum = q.sum + 48'(x);
                d.fsum = q.fsum + 48'(hp);
                p1 = hp * hp;
                d.sq = q.sq + {16'h0000, p1};
                // R12 correlate with sine and cosine
                p1 = x * $signed(sin_rd);
                p2 = x * $signed(cos_rd);
                d.re = q.re + 48'(p1);
                d.im = q.im + 48'(p2);
                // R18 scaled or raw peaks
                pk = (q.txrt[k] == clt_pkg::RT_PEAK) ? smul(x, q.txg[k]) : x;
                // R17 running extremes
                if (pk > q.vmax) d.vmax = pk;
                if (pk < q.vmin) d.vmin = pk;
                d.mcnt = q.mcnt + 16'h0001;
                // R13 count is a power of two by construction
                if (q.mcnt == (16'h0001 << q.mlog) - 16'h0001) begin
                    d.mbusy = 1'b0;
                    d.mfin = 1'b1;
                end
            end
        end

        // R15 averages and their difference
        if (q.mfin) begin
            t48 = q.sum >>> q.mlog;
            d.avg = t48[15:0];
            d.pavg = q.avg;
            d.dif = t48[15:0] - q.avg;
            t48 = q.fsum >>> q.mlog;
            fm = t48[15:0];
            u48 = q.sq >> q.mlog;
            p1 = fm * fm;
            d.vres = u48[15:0] - p1[15:0];
            t48 = q.re >>> ({1'b0, q.mlog} + 5'h0f);
            rn = t48[15:0];
            t48 = q.im >>> ({1'b0, q.mlog} + 5'h0f);
            inn = t48[15:0];
            p1 = rn * rn;
            p2 = inn * inn;
            e33 = {1'b0, p1} + {1'b0, p2};
            d.dft = e33[31:16];
            d.mfin = 1'b0;
            d.mdone = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        if (q.cst == clt_pkg::CAL_EVAL) begin
            // R2 trim against the reference channel
            ra = q.cacc[clt_pkg::REF_CH];
            av = q.cacc[q.cch];
            df = (av > ra) ? av - ra : ra - av;
            lhs = df * clt_pkg::TOL_DEN;
            rhs = ra * clt_pkg::TOL_NUM;
            // R3 outside window fails
            fail = (av == 24'h000000) || (lhs > rhs);
            quo = {ra, 14'h0000} / {14'h0000, av};
            // R4 failed channel left at 0 dB
            trim = fail ? clt_pkg::UNITY : quo[15:0];
            // R5 R21 one mask bit per channel
            if (q.cph) begin
                d.rxtrim[q.cch] = trim;
                d.rxmask[q.cch] = fail;
            end else begin
                d.txtrim[q.cch] = trim;
                d.txmask[q.cch] = fail;
            end
            d.cch = q.cch + 4'h1;
            if (q.cch == 4'hf) d.cst = clt_pkg::CAL_IDLE;
        end

        // R8 pin-loaded firmware and fetch source
        d.tckp = pins_s[2];
        if (pins_s[2] && !q.tckp) begin
            if (!pins_s[1]) begin
                d.jsr = {pins_s[0], q.jsr[31:1]};
            end else begin
                case (q.jsr[31:28])
                    clt_pkg::JT_WR: fw_we = 1'b1;
                    clt_pkg::JT_EXEC: d.jexec = 1'b1;
                    clt_pkg::JT_ROM: d.jexec = 1'b0;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
            q.txrt <= {16{clt_pkg::RT_INACTIVE}};
            q.rxrt <= {16{clt_pkg::RT_INACTIVE}};
            q.txabs <= {16{clt_pkg::UNITY}};
            q.rxabs <= {16{clt_pkg::UNITY}};
            q.txg <= {16{clt_pkg::UNITY}};
            q.rxg <= {16{clt_pkg::UNITY}};
            q.txtrim <= {16{clt_pkg::UNITY}};
            q.rxtrim <= {16{clt_pkg::UNITY}};
        end else if (ce) begin
            q <= d;
        end
    end

    assign host_rdata = q.rdata;
    assign host_rvalid = q.rvalid;
    assign chan_out = q.o;
    assign cal_busy = (q.cst != clt_pkg::CAL_IDLE);
    assign tdo = q.jsr[0];
    assign exec_from_ram = q.jexec;
    // ROM data is external, so only the RAM side is registered here
    assign fetch_data = q.jexec ? fw_rd : rom_data;

    ////////////////////////////////////////////////////////////////////////////
    loop_copy_a: assert property ( // R10
        @(posedge core_clk) disable iff (srst)
        ce && samp.vld && q.txrt[samp.ch] == clt_pkg::RT_LOOP && q.cst == clt_pkg::CAL_IDLE
        |=> chan_out.vld && chan_out.pcm == $past(samp.pcm))
        else $error("loopback data altered");

    cal_inject_a: assert property ( // R1
        @(posedge core_clk) disable iff (srst)
        ce && samp.vld && q.cst == clt_pkg::CAL_ACC
        |=> chan_out.rx == clt_pkg::CAL_AMP || chan_out.rx == 16'h0000 - clt_pkg::CAL_AMP)
        else $error("calibration tone missing");

    cal_start_a: assert property ( // R19
        @(posedge core_clk) disable iff (srst)
        ce && host.wr && host.addr == clt_pkg::A_CMD && host.wdata == clt_pkg::CMD_CAL2
        && !cal_busy |=> cal_busy && q.cph && q.cfrm == 8'h00)
        else $error("second calibration phase not started");

    fail_mask_a: assert property ( // R3
        @(posedge core_clk) disable iff (srst)
        ce && q.cst == clt_pkg::CAL_EVAL && !q.cph &&
        ({q.cacc[q.cch], 1'b0} < q.cacc[clt_pkg::REF_CH] + (q.cacc[clt_pkg::REF_CH] >> 2))
        |=> q.txmask[$past(q.cch)] && q.txtrim[$past(q.cch)] == clt_pkg::UNITY)
        else $error("failed channel not flagged or trimmed");

    ref_trim_a: assert property ( // R2
        @(posedge core_clk) disable iff (srst)
        ce && q.cst == clt_pkg::CAL_EVAL && q.cch == clt_pkg::REF_CH && q.cph
        |=> q.rxtrim[clt_pkg::REF_CH] == clt_pkg::UNITY)
        else $error("reference channel trimmed");

    gain_fold_a: assert property ( // R6
        @(posedge core_clk) disable iff (srst)
        ce && host.wr && in_blk(host.addr, clt_pkg::A_TXG)
        |=> q.txg[$past(host.addr[3:0])] == gmul($past(host.wdata), q.txtrim[$past(host.addr[3:0])]))
        else $error("trim not applied to gain");

    dc_drive_a: assert property ( // R14
        @(posedge core_clk) disable iff (srst)
        ce && samp.vld && q.rxrt[samp.ch] == clt_pkg::RT_DCGEN && !cal_busy
        |=> chan_out.rx == $past(q.dcval) && !chan_out.rx_byp)
        else $error("dc value not driven");

    peak_raw_a: assert property ( // R17
        @(posedge core_clk) disable iff (srst)
        ce && q.mbusy && samp.vld && samp.ch == q.mch && q.txrt[samp.ch] == clt_pkg::RT_PEAKALT
        |=> q.vmax >= $past(samp.tx) && q.vmin <= $past(samp.tx))
        else $error("peak not tracked");

    fw_exec_a: assert property ( // R8
        @(posedge core_clk) disable iff (srst)
        ce && pins_s[2] && !q.tckp && pins_s[1] && q.jsr[31:28] == clt_pkg::JT_EXEC
        |=> exec_from_ram ##1 !ce || exec_from_ram)
        else $error("firmware execution not selected");
endmodule

//--- src/clt_pkg.sv
package clt_pkg;
    // RAM word map seen by the microprocessor port
    localparam logic [15:0] A_CMD = 16'h0002;
    localparam logic [15:0] A_TXMASK = 16'h07f4;
    localparam logic [15:0] A_RXMASK = 16'h07f5;
    localparam logic [15:0] A_TXRT = 16'h0100;
    localparam logic [15:0] A_RXRT = 16'h0110;
    localparam logic [15:0] A_TXG = 16'h0120;
    localparam logic [15:0] A_RXG = 16'h0130;
    localparam logic [15:0] A_STEP = 16'h0140;
    localparam logic [15:0] A_DCVAL = 16'h0141;
    localparam logic [15:0] A_MCH = 16'h0142;
    localparam logic [15:0] A_MLOG = 16'h0143;
    localparam logic [15:0] A_MGO = 16'h0144;
    localparam logic [15:0] A_MSTAT = 16'h0150;
    localparam logic [15:0] A_RDFT = 16'h0151;
    localparam logic [15:0] A_RAVG = 16'h0152;
    localparam logic [15:0] A_RDIF = 16'h0153;
    localparam logic [15:0] A_RVAR = 16'h0154;
    localparam logic [15:0] A_RMAX = 16'h0155;
    localparam logic [15:0] A_RMIN = 16'h0156;
    localparam logic [15:0] A_TXTRIM = 16'h0160;
    localparam logic [15:0] A_RXTRIM = 16'h0170;
    localparam logic [15:0] A_SINE = 16'h0c00;
    // Engine commands
    localparam logic [15:0] CMD_CAL1 = 16'h0700;
    localparam logic [15:0] CMD_CAL2 = 16'h0720;
    // Routine addresses held in the time-slot table
    localparam logic [15:0] RT_ACTIVE = 16'h0200;
    localparam logic [15:0] RT_INACTIVE = 16'h0210;
    localparam logic [15:0] RT_LOOP = 16'h0220;
    localparam logic [15:0] RT_TONE = 16'h0230;
    localparam logic [15:0] RT_DCGEN = 16'h0240;
    localparam logic [15:0] RT_DFT = 16'h0250;
    localparam logic [15:0] RT_DCMEAS = 16'h0260;
    localparam logic [15:0] RT_VAR = 16'h0270;
    localparam logic [15:0] RT_PEAK = 16'h0280;
    localparam logic [15:0] RT_PEAKALT = 16'h0290;
    // Gains are Q2.14, unity is 0 dB
    localparam logic [15:0] UNITY = 16'h4000;
    localparam logic [3:0] REF_CH = 4'h4;
    localparam logic [7:0] CAL_FRAMES = 8'h40;
    localparam logic [15:0] CAL_AMP = 16'h2000;
    // 0.2 dB amplitude window is 23 parts in 1000
    localparam logic [15:0] TOL_NUM = 16'h0017;
    localparam logic [15:0] TOL_DEN = 16'h03e8;
    localparam int HPF_SH = 6;
    localparam logic [3:0] JT_WR = 4'h1;
    localparam logic [3:0] JT_EXEC = 4'h2;
    localparam logic [3:0] JT_ROM = 4'h3;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_ACC = 2'b01,
        CAL_EVAL = 2'b11
    } clt_cal_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } clt_host_t;

    typedef struct packed {
        logic vld;
        logic [3:0] ch;
        logic signed [15:0] tx;
        logic [15:0] pcm;
    } clt_samp_t;

    typedef struct packed {
        logic vld;
        logic [3:0] ch;
        logic [15:0] rx;
        logic [15:0] pcm;
        logic rx_byp;
        logic tx_bpf;
    } clt_out_t;
endpackage

//--- src/clt_ram.sv
`timescale 1ns/1ps
module clt_ram #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Two registered read ports
    input wire logic [AW-1:0] raddr_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_a,
    output logic [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule

//--- src/clt_sync.sv
`timescale 1ns/1ps
module clt_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Pins and clean levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] o;
    } clt_sy_t;
    clt_sy_t q;
    clt_sy_t d;

    // A bit moves only once the second and third stages agree
    always_comb begin
        d = q;
        d.f1 = din;
        d.f2 = q.f1;
        d.f3 = q.f2;
        d.o = (q.f3 & ~(q.f2 ^ q.f3)) | (q.o & (q.f2 ^ q.f3));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign dout = q.o;
endmodule

//--- tb/clt_conv_model.sv
`timescale 1ns/1ps
// Converter channels looped back at the analog side
module clt_conv_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Device side
    input wire clt_pkg::clt_out_t chan_out,
    output clt_pkg::clt_samp_t samp
);
    logic [15:0] rx_q [16];
    logic [3:0] ch_q;
    initial begin
        samp = '0;
        ch_q = 4'h0;
        foreach (rx_q[i]) rx_q[i] = 16'h0000;
    end
    // loopback; channel 7 returns half, so it must fail
    always @(posedge core_clk) begin
        if (chan_out.vld) begin
            rx_q[chan_out.ch] <= chan_out.rx;
        end
        samp.vld <= ~samp.vld & ~srst;
        if (!samp.vld) begin
            samp.ch <= ch_q;
            ch_q <= ch_q + 4'h1;
            samp.tx <= (ch_q == 4'h7) ? {rx_q[ch_q][15], rx_q[ch_q][15:1]} : rx_q[ch_q];
            samp.pcm <= {12'h100, ch_q};
        end
        if (srst) begin
            ch_q <= 4'h0;
        end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    clt_pkg::clt_host_t host = '0;
    logic [15:0] rom_data = 16'h5a5a;
    logic [15:0] host_rdata;
    logic [15:0] fetch_data;
    logic host_rvalid;
    logic cal_busy;
    logic tck = 1'b0;
    logic tms = 1'b0;
    logic tdi = 1'b0;
    logic tdo;
    logic ram_exec;
    clt_pkg::clt_samp_t samp;
    clt_pkg::clt_out_t chan_out;
    int n_fail = 0;
    int n_compared = 0;
    always #2.5 core_clk = ~core_clk;
    // Code fetch stays at word 0, the one word the test port loads
    clt_core u_dut (.core_clk(core_clk), .srst(srst), .ce(1'b1), .host(host),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .samp(samp),
        .chan_out(chan_out), .cal_busy(cal_busy), .tck_pin(tck), .tms_pin(tms),
        .tdi_pin(tdi), .tdo(tdo), .fetch_addr(10'h000), .rom_data(rom_data),
        .fetch_data(fetch_data), .exec_from_ram(ram_exec));
    clt_conv_model u_conv (.core_clk(core_clk), .srst(srst), .chan_out(chan_out),
        .samp(samp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        host.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        host.rd <= 1'b0;
        #1;
        check({15'h0000, host_rvalid}, 16'h0001);
        check(host_rdata, exp);
    endtask
    // Each pin level stands at least 4 cycles so it clears the synchroniser
    task automatic jt(input logic [31:0] w);
        for (int b = 0; b <= 32; b++) begin
            @(posedge core_clk);
            tms <= (b == 32);
            tdi <= w[b % 32];
            repeat (4) @(posedge core_clk);
            tck <= 1'b1;
            repeat (4) @(posedge core_clk);
            tck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait for a condition number: 0 busy high, 1 busy low, 2+ channel out
    task automatic wait_for(input int what);
        int i;
        logic hit;
        i = 0;
        do begin
            @(posedge core_clk);
            #1;
            i++;
            hit = (what == 0) ? cal_busy === 1'b1 : (what == 1) ? cal_busy === 1'b0 :
                chan_out.vld === 1'b1 && chan_out.ch === 4'(what - 2);
        end while (!hit && i < 8000);
        if (!hit) begin
            n_fail++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        check(fetch_data, 16'h5a5a);
        // both phases run right after reset
        wr(clt_pkg::A_CMD, clt_pkg::CMD_CAL1);
        wait_for(0);
        wait_for(1);
        rd(clt_pkg::A_TXMASK, 16'h0080);
        wr(clt_pkg::A_CMD, clt_pkg::CMD_CAL2);
        wait_for(0);
        wait_for(1);
        rd(clt_pkg::A_RXMASK, 16'h0080);
        wr(clt_pkg::A_TXMASK, 16'hffff);
        rd(clt_pkg::A_TXMASK, 16'h0080);
        rd(clt_pkg::A_TXTRIM + 16'h0007, clt_pkg::UNITY);
        rd(clt_pkg::A_TXTRIM + 16'h0004, clt_pkg::UNITY);
        wr(clt_pkg::A_TXRT + 16'h0003, clt_pkg::RT_LOOP);
        wr(clt_pkg::A_DCVAL, 16'h0123);
        wr(clt_pkg::A_RXRT + 16'h0005, clt_pkg::RT_DCGEN);
        wr(clt_pkg::A_RXRT + 16'h0006, clt_pkg::RT_TONE);
        // Skip one frame so every routine change has landed
        wait_for(17);
        wait_for(5);
        check(chan_out.pcm, 16'h1003);
        wait_for(7);
        check(chan_out.rx, 16'h0123);
        wait_for(8);
        check({15'h0000, chan_out.rx_byp}, 16'h0001);
        wr(clt_pkg::A_TXG + 16'h0002, 16'h2000);
        rd(clt_pkg::A_TXG + 16'h0002, 16'h2000);
        // Channel 5 loops its dc value back, so average, difference and both peaks read that value
        wr(clt_pkg::A_TXRT + 16'h0005, clt_pkg::RT_PEAKALT);
        wr(clt_pkg::A_MCH, 16'h0005);
        wr(clt_pkg::A_MLOG, 16'h0002);
        wr(clt_pkg::A_MGO, 16'h0001);
        repeat (200) @(posedge core_clk);
        rd(clt_pkg::A_MSTAT, 16'h0002);
        rd(clt_pkg::A_RAVG, 16'h0123);
        rd(clt_pkg::A_RDIF, 16'h0123);
        rd(clt_pkg::A_RMAX, 16'h0123);
        rd(clt_pkg::A_RMIN, 16'h0123);
        jt(32'h1000_1235);
        check({15'h0000, tdo}, 16'h0001);
        jt(32'h2000_0000);
        check({15'h0000, ram_exec}, 16'h0001);
        check(fetch_data, 16'h1235);
        end_sim();
    end
endmodule
